// ==== logic/charger_regs_pkg.sv ====
`default_nettype none
package charger_regs_pkg;
   // ------------------------------------------------------------------
   // command codes of the write-word / read-word transactions
   // ------------------------------------------------------------------
   localparam logic [7:0] CMD_CEILING = 8'h15;
   localparam logic [7:0] CMD_FLOOR = 8'h3e;
   localparam logic [7:0] CMD_THRESHOLD = 8'h47;

   // ------------------------------------------------------------------
   // field masks, saturation values and reset values
   // ------------------------------------------------------------------
   // ceiling: bits 14:3, 8 mV per step, 18304 mV = 2288 steps
   localparam logic [15:0] CEILING_MASK = 16'h7ff8;
   localparam logic [15:0] CEILING_MAX = 16'h4780;
   localparam logic [15:0] CEILING_RESET = 16'h0000;
   // floor: bits 13:8, 256 mV per step, 13824 mV = 54 steps
   localparam logic [15:0] FLOOR_MASK = 16'h3f00;
   localparam logic [15:0] FLOOR_MAX = 16'h3600;
   localparam logic [15:0] FLOOR_RESET = 16'h0000;
   // threshold: bits 12:7, 128 mA per step, 6400 mA = 6'b110010
   localparam logic [15:0] THRESHOLD_MASK = 16'h1f80;
   localparam logic [15:0] THRESHOLD_MAX = 16'h1900;
   localparam logic [15:0] THRESHOLD_RESET = 16'h0c00;

   // ------------------------------------------------------------------
   // timing: alert counters step once per microsecond tick
   // ------------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   localparam int TICK_NS = 1000;
   localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
   localparam int TICK_W = 7;
   localparam int US_W = 16;

   // alert sequencer, gray along idle -> debounce -> hold
   typedef enum logic [1:0] {
      ALERT_IDLE = 2'b00,
      ALERT_DEBOUNCE = 2'b01,
      ALERT_HOLD = 2'b11
   } alert_state_t;
endpackage : charger_regs_pkg
`default_nettype wire

// ==== logic/charger_voltage_prochot_regs.sv ====
`timescale 1ns/1ns
`default_nettype none
module charger_voltage_prochot_regs
   import charger_regs_pkg::*;
#(
   // debounce choices 0..3 in microseconds, entry 0 in the low bits
   parameter logic [4*US_W-1:0] DEBOUNCE_US = {16'd100, 16'd50, 16'd25, 16'd10},
   // minimum hold choices 0..7 in microseconds, entry 0 in the low bits
   parameter logic [8*US_W-1:0] HOLD_US = {16'd10000, 16'd5000, 16'd2000, 16'd1000,
                                           16'd500, 16'd100, 16'd20, 16'd10}
) (
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire logic [7:0] cmd_code_i,
   input wire logic [15:0] wr_data_i,
   input wire logic wr_word_i,
   input wire logic rd_word_i,
   input wire logic [15:0] batt_voltage_i,
   input wire logic [15:0] adapter_current_i,
   input wire logic charging_i,
   input wire logic learn_en_i,
   input wire logic [1:0] debounce_sel_i,
   input wire logic [2:0] hold_sel_i,
   output logic cmd_ack_o,
   output logic cmd_nack_o,
   output logic [15:0] rd_data_o,
   output logic rd_valid_o,
   output logic [15:0] ceiling_o,
   output logic [15:0] floor_o,
   output logic batt_below_floor_o,
   output logic trickle_mode_o,
   output logic learn_mode_o,
   output logic prochot_o,
   output logic prochot_oe_n_o
);

   // ------------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------------
   // strip unused bits and clamp at the field maximum
   function automatic logic [15:0] saturate(input logic [15:0] value,
                                            input logic [15:0] mask,
                                            input logic [15:0] max_value);
      logic [15:0] kept;
      kept = value & mask;
      saturate = (kept > max_value) ? max_value : kept;
   endfunction : saturate

   // ------------------------------------------------------------------
   // command decode
   // ------------------------------------------------------------------
   logic [15:0] ceiling;
   logic [15:0] floor_v;
   logic [15:0] threshold;
   wire hit_ceiling = (cmd_code_i == CMD_CEILING);
   wire hit_floor = (cmd_code_i == CMD_FLOOR);
   wire hit_threshold = (cmd_code_i == CMD_THRESHOLD);
   wire hit_any = hit_ceiling | hit_floor | hit_threshold;
   wire [15:0] next_ceiling = saturate(wr_data_i, CEILING_MASK, CEILING_MAX);
   wire [15:0] next_floor = saturate(wr_data_i, FLOOR_MASK, FLOOR_MAX);
   wire [15:0] next_threshold = saturate(wr_data_i, THRESHOLD_MASK, THRESHOLD_MAX);
   wire ceiling_we = wr_word_i & hit_ceiling & (next_ceiling != 16'h0000);
   // unmapped reads answer zero so no stale data leaks out
   wire [15:0] rd_mux = hit_ceiling ? ceiling :
                        hit_floor ? floor_v :
                        hit_threshold ? threshold : 16'h0000;

   // ------------------------------------------------------------------
   // register bank
   // ------------------------------------------------------------------
   // ceiling write-word store
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ceiling <= CEILING_RESET;
      end else if (ceiling_we) begin
         ceiling <= next_ceiling;
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         floor_v <= FLOOR_RESET;
      end else if (wr_word_i && hit_floor) begin
         floor_v <= next_floor;
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         threshold <= THRESHOLD_RESET;
      end else if (wr_word_i && hit_threshold) begin
         threshold <= next_threshold;
      end
   end

   // answers: one-cycle ack/nack and read data the cycle after the request
   // read-back of stored contents
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cmd_ack_o <= 1'b0;
         cmd_nack_o <= 1'b0;
         rd_valid_o <= 1'b0;
         rd_data_o <= 16'h0000;
      end else begin
         cmd_ack_o <= (wr_word_i | rd_word_i) & hit_any;
         cmd_nack_o <= (wr_word_i | rd_word_i) & ~hit_any;
         rd_valid_o <= rd_word_i;
         rd_data_o <= rd_word_i ? rd_mux : 16'h0000;
      end
   end

   // ------------------------------------------------------------------
   // floor comparison and mode decisions
   // ------------------------------------------------------------------
   // floor above ceiling is the host's mistake and is not policed
   wire below_now = (batt_voltage_i & FLOOR_MASK) < floor_v;

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         batt_below_floor_o <= 1'b0;
         trickle_mode_o <= 1'b0;
         learn_mode_o <= 1'b0;
      end else begin
         batt_below_floor_o <= below_now;
         trickle_mode_o <= charging_i & below_now;
         learn_mode_o <= learn_en_i & ~below_now;
      end
   end

   // mirrors for the regulation loop, registered as the outputs demand
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ceiling_o <= CEILING_RESET;
         floor_o <= FLOOR_RESET;
      end else begin
         ceiling_o <= ceiling;
         floor_o <= floor_v;
      end
   end

   // ------------------------------------------------------------------
   // microsecond tick divider
   // ------------------------------------------------------------------
   logic [TICK_W-1:0] tick_cnt;
   logic us_tick;
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tick_cnt <= '0;
         us_tick <= 1'b0;
      end else begin
         us_tick <= (tick_cnt == TICK_W'(TICK_CYCLES - 1));
         tick_cnt <= (tick_cnt == TICK_W'(TICK_CYCLES - 1)) ? '0 : tick_cnt + 1'b1;
      end
   end

   // ------------------------------------------------------------------
   // adapter overcurrent alert
   // ------------------------------------------------------------------
   // the current code arrives in the threshold's own format, so the
   // compare is a plain magnitude test on the kept bits
   logic over_q;
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         over_q <= 1'b0;
      end else begin
         over_q <= (adapter_current_i & THRESHOLD_MASK) > threshold;
      end
   end

   alert_state_t state;
   alert_state_t next_state;
   logic [US_W-1:0] us_cnt;
   // selections are sampled live; a change mid-wait shortens or stretches it
   wire [US_W-1:0] debounce_limit = DEBOUNCE_US[debounce_sel_i*US_W +: US_W];
   wire [US_W-1:0] hold_limit = HOLD_US[hold_sel_i*US_W +: US_W];
   wire debounce_done = (us_cnt >= debounce_limit);
   wire hold_done = (us_cnt >= hold_limit);

   always_comb begin
      next_state = state;
      case (state)
         ALERT_IDLE: begin
            if (over_q) next_state = ALERT_DEBOUNCE;
         end
         ALERT_DEBOUNCE: begin
            if (!over_q) next_state = ALERT_IDLE;
            else if (debounce_done) next_state = ALERT_HOLD;
         end
         ALERT_HOLD: begin
            if (hold_done && !over_q) next_state = ALERT_IDLE;
         end
         default: begin
            next_state = ALERT_IDLE;
         end
      endcase
   end

   // counter restarts on every state change, saturates to avoid wrap
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state <= ALERT_IDLE;
         us_cnt <= '0;
      end else begin
         state <= next_state;
         if (next_state != state) us_cnt <= '0;
         else if (us_tick && us_cnt != '1) us_cnt <= us_cnt + 1'b1;
      end
   end

   // pin drive: enable low pulls the open-drain line low
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         prochot_o <= 1'b0;
         prochot_oe_n_o <= 1'b1;
      end else begin
         prochot_o <= (next_state == ALERT_HOLD);
         prochot_oe_n_o <= (next_state != ALERT_HOLD);
      end
   end

   // ------------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------------
   sequence s_over_held;
      over_q [*2];
   endsequence

   a_ceil_store: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      wr_word_i && hit_ceiling && next_ceiling != 16'h0000
      |=> ceiling == saturate($past(wr_data_i), CEILING_MASK, CEILING_MAX))
      else $error("ceiling write not stored");
   a_ceil_saturate: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      ceiling <= CEILING_MAX) else $error("ceiling above its maximum");
   a_ceil_zero_kept: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      wr_word_i && hit_ceiling && (wr_data_i & CEILING_MASK) == 16'h0000
      |=> $stable(ceiling) ##0 cmd_ack_o) else $error("zero ceiling changed register");
   a_ceil_unused: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      (ceiling & ~CEILING_MASK) == 16'h0000) else $error("ceiling unused bit set");
   a_floor_store: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      wr_word_i && hit_floor |=> floor_v == saturate($past(wr_data_i), FLOOR_MASK, FLOOR_MAX))
      else $error("floor write not stored");
   a_floor_bits: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      (floor_v & ~FLOOR_MASK) == 16'h0000 && floor_v <= FLOOR_MAX)
      else $error("floor out of format");
   a_below_floor: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      ##1 batt_below_floor_o == ((($past(batt_voltage_i) & FLOOR_MASK)) < $past(floor_v)))
      else $error("floor compare wrong");
   a_thr_store: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      wr_word_i && hit_threshold
      |=> threshold == saturate($past(wr_data_i), THRESHOLD_MASK, THRESHOLD_MAX))
      else $error("threshold write not stored");
   a_thr_bits: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      (threshold & ~THRESHOLD_MASK) == 16'h0000 && threshold <= THRESHOLD_MAX)
      else $error("threshold out of format");
   a_thr_readback: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      rd_word_i && hit_threshold |=> rd_valid_o && rd_data_o == $past(threshold))
      else $error("threshold read-back wrong");
   a_alert_debounce: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      $rose(prochot_o) |-> $past(over_q) && $past(debounce_done) && !prochot_oe_n_o)
      else $error("alert raised before debounce ran out");
   a_alert_hold: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      $fell(prochot_o) |-> $past(hold_done)) else $error("alert released before hold");
   // the alert follows one cycle after a debounce that ran out under overcurrent
   a_alert_raise: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      s_over_held ##0 (state == ALERT_DEBOUNCE && debounce_done)
      |=> prochot_o && !prochot_oe_n_o) else $error("alert late after debounce");
   a_hold_latch: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      state == ALERT_HOLD && !hold_done |=> prochot_o)
      else $error("alert dropped inside hold");
endmodule : charger_voltage_prochot_regs
`default_nettype wire

// ==== testbench/smbus_host_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module smbus_host_model (
   input wire logic sys_clk_i,
   input wire logic cmd_ack_i,
   input wire logic cmd_nack_i,
   input wire logic rd_valid_i,
   input wire logic [15:0] rd_data_i,
   output logic [7:0] cmd_code_o,
   output logic [15:0] wr_data_o,
   output logic wr_word_o,
   output logic rd_word_o
);
   // ------------------------------------------------------------------
   // host side of the decoded word port
   // ------------------------------------------------------------------
   // idle values at time zero, strobes low
   initial begin
      cmd_code_o = 8'h00;
      wr_data_o = 16'h0000;
      wr_word_o = 1'b0;
      rd_word_o = 1'b0;
   end

   task automatic write_word(input logic [7:0] cmd, input logic [15:0] data,
                             output logic [1:0] resp);
      @(posedge sys_clk_i);
      #1;
      cmd_code_o = cmd;
      wr_data_o = data;
      wr_word_o = 1'b1;
      @(posedge sys_clk_i);
      #1;
      wr_word_o = 1'b0;
      // released lines are scrambled so a stale value never passes for a live one
      cmd_code_o = ~cmd;
      wr_data_o = ~data;
      resp = {cmd_ack_i, cmd_nack_i};
   endtask : write_word

   // read word, answer taken in the single cycle it stands
   task automatic read_word(input logic [7:0] cmd, output logic [15:0] data,
                            output logic [1:0] resp);
      @(posedge sys_clk_i);
      #1;
      cmd_code_o = cmd;
      rd_word_o = 1'b1;
      @(posedge sys_clk_i);
      #1;
      rd_word_o = 1'b0;
      cmd_code_o = ~cmd;
      data = rd_valid_i ? rd_data_i : ~rd_data_i;
      resp = {cmd_ack_i, cmd_nack_i};
   endtask : read_word
endmodule : smbus_host_model
`default_nettype wire

// ==== testbench/tb_top.sv ====
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   import charger_regs_pkg::*;
   // ------------------------------------------------------------------
   // clock, reset and wiring
   // ------------------------------------------------------------------
   logic sys_clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic [7:0] cmd_code;
   logic [15:0] wr_data;
   logic wr_word, rd_word, cmd_ack, cmd_nack, rd_valid;
   logic [15:0] rd_data, ceiling, floor_q, rdv;
   logic [15:0] batt_voltage = 16'h0000;
   logic [15:0] adapter_current = 16'h0000;
   logic charging = 1'b0;
   logic learn_en = 1'b0;
   logic [1:0] debounce_sel = 2'b00;
   logic [2:0] hold_sel = 3'b000;
   logic below, trickle, learn_mode, prochot, prochot_oe_n;
   logic [1:0] resp;
   int failures = 0;
   int comparisons = 0;
   int n;

   always #5 sys_clk_i = ~sys_clk_i;

   // short microsecond tables keep the alert runs brief
   charger_voltage_prochot_regs #(
      .DEBOUNCE_US({16'd8, 16'd6, 16'd4, 16'd2}),
      .HOLD_US({16'd9, 16'd8, 16'd7, 16'd6, 16'd5, 16'd4, 16'd3, 16'd2})
   ) u_dut (
      .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .cmd_code_i(cmd_code),
      .wr_data_i(wr_data), .wr_word_i(wr_word), .rd_word_i(rd_word),
      .batt_voltage_i(batt_voltage), .adapter_current_i(adapter_current),
      .charging_i(charging), .learn_en_i(learn_en), .debounce_sel_i(debounce_sel),
      .hold_sel_i(hold_sel), .cmd_ack_o(cmd_ack), .cmd_nack_o(cmd_nack),
      .rd_data_o(rd_data), .rd_valid_o(rd_valid), .ceiling_o(ceiling), .floor_o(floor_q),
      .batt_below_floor_o(below), .trickle_mode_o(trickle), .learn_mode_o(learn_mode),
      .prochot_o(prochot), .prochot_oe_n_o(prochot_oe_n)
   );

   smbus_host_model u_host (
      .sys_clk_i(sys_clk_i), .cmd_ack_i(cmd_ack), .cmd_nack_i(cmd_nack),
      .rd_valid_i(rd_valid), .rd_data_i(rd_data), .cmd_code_o(cmd_code),
      .wr_data_o(wr_data), .wr_word_o(wr_word), .rd_word_o(rd_word)
   );

   // ------------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------------
   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         failures++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   // write, then read back; response code is {ack, nack}
   task automatic wr_rd(input logic [7:0] cmd, input logic [15:0] d, input logic [15:0] exp,
                        input logic [1:0] exp_resp);
      u_host.write_word(cmd, d, resp);
      check("write response", {14'h0, resp}, {14'h0, exp_resp});
      u_host.read_word(cmd, rdv, resp);
      check("read response", {14'h0, resp}, {14'h0, exp_resp});
      check("read data", rdv, exp);
   endtask : wr_rd

   // sample one time unit after the edge so its updates have landed
   task automatic tick(input int k);
      repeat (k) @(posedge sys_clk_i);
      #1;
   endtask : tick

   task automatic finish_test();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : finish_test

   // a hang counts as a mismatch; the full run needs well under this
   initial begin
      repeat (30000) @(posedge sys_clk_i);
      failures++;
      finish_test();
   end

   // ------------------------------------------------------------------
   // test sequence
   // ------------------------------------------------------------------
   initial begin
      tick(8);
      rst_n_i = 1'b1;
      u_host.read_word(CMD_THRESHOLD, rdv, resp);
      check("threshold reset", rdv, 16'h0c00);
      wr_rd(CMD_THRESHOLD, 16'hffff, 16'h1900, 2'b10);
      wr_rd(CMD_THRESHOLD, 16'h1980, 16'h1900, 2'b10);
      wr_rd(CMD_THRESHOLD, 16'h0000, 16'h0000, 2'b10);
      wr_rd(CMD_THRESHOLD, 16'he07f, 16'h0000, 2'b10);
      wr_rd(CMD_THRESHOLD, 16'h0c80, 16'h0c80, 2'b10);
      wr_rd(CMD_CEILING, 16'h1237, 16'h1230, 2'b10);
      wr_rd(CMD_CEILING, 16'hffff, 16'h4780, 2'b10);
      wr_rd(CMD_CEILING, 16'h0007, 16'h4780, 2'b10);
      wr_rd(CMD_CEILING, 16'h8000, 16'h4780, 2'b10);
      check("ceiling out", ceiling, 16'h4780);
      wr_rd(CMD_FLOOR, 16'hffff, 16'h3600, 2'b10);
      wr_rd(CMD_FLOOR, 16'hea55, 16'h2a00, 2'b10);
      check("floor out", floor_q, 16'h2a00);
      wr_rd(8'h20, 16'hffff, 16'h0000, 2'b01);
      // battery under the floor, then exactly on it
      charging = 1'b1;
      learn_en = 1'b1;
      batt_voltage = 16'h29ff;
      tick(3);
      check("mode flags", {13'h0, below, trickle, learn_mode}, 16'h0006);
      batt_voltage = 16'h2a00;
      tick(3);
      check("mode flags", {13'h0, below, trickle, learn_mode}, 16'h0001);
      // all eight hold choices; the debounce choices repeat in the upper half
      for (int s = 0; s < 8; s++) begin
         debounce_sel = s[1:0];
         hold_sel = s[2:0];
         adapter_current = 16'h1f80;
         tick(100 * (2 * (s % 4) + 1));
         check("alert early", {15'h0, prochot}, 16'h0000);
         n = 0;
         while (prochot !== 1'b1 && n < 300) begin
            tick(1);
            n++;
         end
         check("alert raised", {15'h0, prochot}, 16'h0001);
         check("pin driven", {15'h0, prochot_oe_n}, 16'h0000);
         adapter_current = 16'h0000;
         tick(100 * (s + 1) - 5);
         check("alert held", {15'h0, prochot}, 16'h0001);
         n = 0;
         while (prochot !== 1'b0 && n < 300) begin
            tick(1);
            n++;
         end
         check("alert released", {14'h0, prochot, prochot_oe_n}, 16'h0001);
      end
      finish_test();
   end
endmodule : tb_top
`default_nettype wire
